// ==== logic/dbi_pkg.sv ====
// Shared constants and types for the external bus interface block
`default_nettype none

package dbi_pkg;

  // ****************************************
  // Bus widths and machine cycle
  // ****************************************
  localparam int ADDR_W = 12;
  localparam int DATA_W = 16;
  localparam int PORT_W = 3;
  localparam int PIN_COUNT = 4;
  // Four input clocks make one machine cycle
  localparam logic [1:0] PHASE_LAST = 2'h3;
  localparam logic [1:0] PHASE_FIRST = 2'h0;
  // Cycle clock output is high in phases 0 and 1
  localparam logic [1:0] PHASE_CLK_FALL = 2'h2;
  localparam logic [1:0] RESET_ENDS_DONE = 2'h2;
  localparam logic [1:0] RESET_ENDS_CLEAR = 2'h1;
  localparam int RESET_MIN_CYCLES = 5;

  // ****************************************
  // Program memory map
  // ****************************************
  localparam int ONCHIP_WORDS = 1524;
  localparam int ONCHIP_AW = 11;
  localparam logic [11:0] ONCHIP_LIMIT = 12'h5F4;
  localparam logic [11:0] RESERVED_END = 12'h5FF;
  localparam logic [11:0] PC_RESET = 12'h000;
  localparam logic [11:0] INT_VECTOR = 12'h002;

  // ****************************************
  // Register port map and fields
  // ****************************************
  localparam logic [2:0] REG_CTRL = 3'h0;
  localparam logic [2:0] REG_STATUS = 3'h1;
  localparam logic [2:0] REG_PC = 3'h2;
  localparam logic [2:0] REG_MEM_ADDR = 3'h3;
  localparam logic [2:0] REG_MEM_DATA = 3'h4;
  localparam int CTRL_INT_EN_BIT = 0;
  localparam int CTRL_OVM_BIT = 1;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam int STAT_FLAG_BIT = 0;
  localparam int STAT_MODE_BIT = 1;
  localparam int STAT_TEST_BIT = 2;
  localparam int STAT_RESET_BIT = 3;
  localparam int STAT_IRQ_BIT = 4;
  // Pin synchroniser idle levels: mode, test, interrupt, reset
  localparam logic [3:0] PIN_IDLE = 4'hF;

  // ****************************************
  // Core requests and sequencer states
  // ****************************************
  typedef enum logic [2:0] {OP_NEXT, OP_JUMP, OP_BRANCH_TEST, OP_IN, OP_OUT, OP_TABLE_READ_OP, OP_TABLE_WRITE_OP} dbi_op_t;
  typedef enum logic [2:0] {ST_RESET, ST_FETCH, ST_IO, ST_TBL_DUMMY, ST_TBL_XFER} dbi_state_t;

endpackage

`default_nettype wire

// ==== logic/dbi_pin_sync.sv ====
// Three-stage pin synchroniser with agreement filter
`default_nettype none

module dbi_pin_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] IDLE = '1
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [WIDTH-1:0] pins_in,
  output logic [WIDTH-1:0] pins_out
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  logic [WIDTH-1:0] next_stable;
  logic [WIDTH-1:0] agree;

  // A bit changes only once stages two and three agree
  always_comb
  begin
    agree = ~(stage2 ^ stage3);
    next_stable = (agree & stage3) | (~agree & pins_out);
  end

  // Stage one feeds stage two and nothing else
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      stage1 <= IDLE;
      stage2 <= IDLE;
      stage3 <= IDLE;
      pins_out <= IDLE;
    end
    else
    begin
      stage1 <= pins_in;
      stage2 <= stage1;
      stage3 <= stage2;
      pins_out <= next_stable;
    end
  end

endmodule

`default_nettype wire

// ==== logic/dbi_prog_mem.sv ====
// On-chip program store with registered read data
`default_nettype none

module dbi_prog_mem #(
  parameter int DEPTH = 1524,
  parameter int AW = 11,
  parameter int DW = 16
) (
  input wire logic clk_in,
  input wire logic wr_en_in,
  input wire logic [AW-1:0] wr_addr_in,
  input wire logic [DW-1:0] wr_data_in,
  input wire logic [AW-1:0] rd_addr_in,
  output logic [DW-1:0] rd_data_out
);

  logic [DW-1:0] mem [DEPTH];

  // Out-of-range words read as zero and ignore writes
  always_ff @(posedge clk_in)
  begin
    if (wr_en_in && (wr_addr_in < AW'(DEPTH)))
    begin
      mem[wr_addr_in] <= wr_data_in;
    end
    if (rd_addr_in < AW'(DEPTH))
    begin
      rd_data_out <= mem[rd_addr_in];
    end
    else
    begin
      rd_data_out <= '0;
    end
  end

endmodule

`default_nettype wire

// ==== logic/dbi_bus_if.sv ====
// Pin-level external bus interface with cycle sequencer
//
// Chosen here: the address-and-strobe port and the register offsets.
`default_nettype none

// Notes on behaviour
// - Cycle clock output and machine cycle run at a quarter rate, half high.
// - Write strobe low only in output-port cycle and table-write transfer cycle.
// - While write strobe is low, fetch and input strobes stay high.
// - Input strobe low only in the input-port cycle.
// - While input strobe is low, fetch and write strobes stay high.
// - Fetch strobe low on every machine cycle except port, table-write transfer and reset cycles.
// - Fetch strobe also asserted for on-chip program words.
// - Reset pin held low five cycles; strobes high, data bus released.
// - After one complete cycle in reset, program counter and address clear.
// - Pin reset disables interrupts, clears flag, keeps overflow mode.
// - Interrupt falling edge sets flag until granted; low level also requests.
// - Branch test low during branch op jumps to target, else continues.
// - Mode high: 1524 words on-chip, 1524..1535 reserved, rest off-chip.
// - Mode low: every address 0..4095 comes from outside.
// - Data bus released except while write strobe is low.
// - Twelve address outputs are always driven.
// - Port number appears on the three low address lines for port ops.
// - Upper nine address lines are zero during port ops.
// - Branch test level is sampled each cycle, never latched.
module dbi_bus_if (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic reset_pin_n_in,
  input wire logic interrupt_pin_n_in,
  input wire logic branch_test_input_n_in,
  input wire logic memory_mode_select_in,
  output logic cycle_clock_output_out,
  output logic fetch_strobe_n_out,
  output logic input_read_strobe_n_out,
  output logic write_strobe_n_out,
  output logic [dbi_pkg::ADDR_W-1:0] address_out,
  input wire logic [dbi_pkg::DATA_W-1:0] data_bus_in,
  output logic [dbi_pkg::DATA_W-1:0] data_bus_out,
  output logic data_bus_oe_n_out,
  input wire dbi_pkg::dbi_op_t op_in,
  input wire logic op_valid_in,
  output logic op_ready_out,
  input wire logic [dbi_pkg::ADDR_W-1:0] op_addr_in,
  input wire logic [dbi_pkg::DATA_W-1:0] op_data_in,
  output logic [dbi_pkg::DATA_W-1:0] fetch_word_out,
  output logic fetch_valid_out,
  output logic [dbi_pkg::DATA_W-1:0] result_data_out,
  output logic result_valid_out,
  output logic branch_taken_out,
  output logic irq_taken_out,
  input wire logic [2:0] reg_addr_in,
  input wire logic [dbi_pkg::DATA_W-1:0] reg_wdata_in,
  input wire logic reg_write_in,
  input wire logic reg_read_in,
  output logic [dbi_pkg::DATA_W-1:0] reg_rdata_out
);
  import dbi_pkg::*;

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [PIN_COUNT-1:0] pins_sync;
  logic pin_reset_n;
  logic pin_int_n;
  logic pin_test_n;
  logic pin_mode;

  // Outside parties are expected to present clean, held levels
  dbi_pin_sync #(.WIDTH(PIN_COUNT), .IDLE(PIN_IDLE)) u_sync (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .pins_in({memory_mode_select_in, branch_test_input_n_in, interrupt_pin_n_in, reset_pin_n_in}),
    .pins_out(pins_sync)
  );
  assign pin_reset_n = pins_sync[0];
  assign pin_int_n = pins_sync[1];
  assign pin_test_n = pins_sync[2];
  assign pin_mode = pins_sync[3];

  // ****************************************
  // Quarter-rate divider
  // ****************************************
  logic [1:0] phase;
  logic [1:0] next_phase;
  logic next_cycle_clock;
  logic cycle_end;

  // Output clock is registered, so it has no glitches; skew to clk_in is free
  always_comb
  begin
    next_phase = phase + 2'h1;
    next_cycle_clock = (next_phase < PHASE_CLK_FALL);
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      phase <= PHASE_FIRST;
      cycle_clock_output_out <= 1'b1;
    end
    else
    begin
      phase <= next_phase;
      cycle_clock_output_out <= next_cycle_clock;
    end
  end

  assign cycle_end = (phase == PHASE_LAST);

  // ****************************************
  // Control register and interrupt flag
  // ****************************************
  logic int_en;
  logic ovm;
  logic flag;
  logic int_prev;
  logic next_int_en;
  logic next_ovm;
  logic next_flag;
  logic irq_request;
  logic grant;
  logic [ONCHIP_AW-1:0] mem_ptr;
  logic [ONCHIP_AW-1:0] next_mem_ptr;
  logic mem_we;

  assign irq_request = int_en && (flag || !pin_int_n);
  assign mem_we = reg_write_in && (reg_addr_in == REG_MEM_DATA);

  // Pin reset beats a grant, and a grant beats a software write
  always_comb
  begin
    next_int_en = int_en;
    next_ovm = ovm;
    next_flag = flag;
    next_mem_ptr = mem_ptr;
    if (reg_write_in && (reg_addr_in == REG_CTRL))
    begin
      next_int_en = reg_wdata_in[CTRL_INT_EN_BIT];
      next_ovm = reg_wdata_in[CTRL_OVM_BIT];
    end
    if (reg_write_in && (reg_addr_in == REG_MEM_ADDR))
    begin
      next_mem_ptr = reg_wdata_in[ONCHIP_AW-1:0];
    end
    if (mem_we)
    begin
      next_mem_ptr = mem_ptr + 11'h001;
    end
    if (grant)
    begin
      next_int_en = 1'b0;
      next_flag = 1'b0;
    end
    // A new edge in the grant cycle is kept
    if (int_prev && !pin_int_n)
    begin
      next_flag = 1'b1;
    end
    if (!pin_reset_n)
    begin
      next_int_en = 1'b0;
      next_flag = 1'b0;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      int_en <= CTRL_RESET[CTRL_INT_EN_BIT];
      ovm <= CTRL_RESET[CTRL_OVM_BIT];
      flag <= 1'b0;
      int_prev <= 1'b1;
      mem_ptr <= '0;
    end
    else
    begin
      int_en <= next_int_en;
      ovm <= next_ovm;
      flag <= next_flag;
      int_prev <= pin_int_n;
      mem_ptr <= next_mem_ptr;
    end
  end

  // ****************************************
  // Program store and read-word select
  // ****************************************
  logic [DATA_W-1:0] mem_rdata;
  logic [DATA_W-1:0] read_word;

  dbi_prog_mem #(.DEPTH(ONCHIP_WORDS), .AW(ONCHIP_AW), .DW(DATA_W)) u_mem (
    .clk_in(clk_in),
    .wr_en_in(mem_we),
    .wr_addr_in(mem_ptr),
    .wr_data_in(reg_wdata_in),
    .rd_addr_in(address_out[ONCHIP_AW-1:0]),
    .rd_data_out(mem_rdata)
  );

  // Reserved words read as zero; bus is sampled late in the cycle when stable
  always_comb
  begin
    if (pin_mode && (address_out < ONCHIP_LIMIT))
    begin
      read_word = mem_rdata;
    end
    else if (pin_mode && (address_out <= RESERVED_END))
    begin
      read_word = '0;
    end
    else
    begin
      read_word = data_bus_in;
    end
  end

  // ****************************************
  // Machine-cycle sequencer
  // ****************************************
  dbi_state_t state;
  dbi_state_t next_state;
  dbi_op_t cur_op;
  dbi_op_t next_cur_op;
  logic [ADDR_W-1:0] pc;
  logic [ADDR_W-1:0] next_pc;
  logic [ADDR_W-1:0] next_addr;
  logic [ADDR_W-1:0] opa;
  logic [ADDR_W-1:0] next_opa;
  logic [DATA_W-1:0] opd;
  logic [DATA_W-1:0] next_opd;
  logic [1:0] rst_ends;
  logic [1:0] next_rst_ends;
  logic [DATA_W-1:0] next_fetch_word;
  logic [DATA_W-1:0] next_result;
  logic next_fetch_valid;
  logic next_result_valid;
  logic next_branch;
  logic next_irq_taken;
  logic next_fetch_n;
  logic next_read_n;
  logic next_write_n;
  logic strobe_on;

  // Requests are taken only at a fetch cycle boundary
  assign op_ready_out = cycle_end && (state == ST_FETCH) && pin_reset_n && !irq_request;

  always_comb
  begin
    next_state = state;
    next_cur_op = cur_op;
    next_pc = pc;
    next_addr = address_out;
    next_opa = opa;
    next_opd = opd;
    next_rst_ends = rst_ends;
    next_fetch_word = fetch_word_out;
    next_result = result_data_out;
    next_fetch_valid = 1'b0;
    next_result_valid = 1'b0;
    next_branch = 1'b0;
    next_irq_taken = 1'b0;
    grant = 1'b0;
    if (!pin_reset_n)
    begin
      // Held in reset for as long as the pin stays low
      next_state = ST_RESET;
      if (cycle_end && (rst_ends != RESET_ENDS_DONE))
      begin
        next_rst_ends = rst_ends + 2'h1;
      end
      if (cycle_end && (rst_ends == RESET_ENDS_CLEAR))
      begin
        next_pc = PC_RESET;
        next_addr = PC_RESET;
      end
    end
    else if (cycle_end)
    begin
      next_rst_ends = 2'h0;
      unique case (state)
        ST_RESET:
        begin
          next_state = ST_FETCH;
        end
        ST_FETCH:
        begin
          next_fetch_word = read_word;
          next_fetch_valid = 1'b1;
          if (irq_request)
          begin
            grant = 1'b1;
            next_irq_taken = 1'b1;
            next_pc = INT_VECTOR;
          end
          else if (op_valid_in)
          begin
            next_cur_op = op_in;
            next_opa = op_addr_in;
            next_opd = op_data_in;
            unique case (op_in)
              OP_NEXT: next_pc = pc + 12'h001;
              OP_JUMP: next_pc = op_addr_in;
              OP_BRANCH_TEST:
              begin
                // Live level of the test pin, nothing latched
                if (!pin_test_n)
                begin
                  next_pc = op_addr_in;
                  next_branch = 1'b1;
                end
                else
                begin
                  next_pc = pc + 12'h001;
                end
              end
              OP_IN, OP_OUT: next_state = ST_IO;
              OP_TABLE_READ_OP, OP_TABLE_WRITE_OP: next_state = ST_TBL_DUMMY;
              default: next_pc = pc + 12'h001;
            endcase
          end
        end
        ST_IO:
        begin
          if (cur_op == OP_IN)
          begin
            next_result = data_bus_in;
            next_result_valid = 1'b1;
          end
          next_pc = pc + 12'h001;
          next_state = ST_FETCH;
        end
        ST_TBL_DUMMY:
        begin
          next_state = ST_TBL_XFER;
        end
        ST_TBL_XFER:
        begin
          if (cur_op == OP_TABLE_READ_OP)
          begin
            next_result = read_word;
            next_result_valid = 1'b1;
          end
          next_pc = pc + 12'h001;
          next_state = ST_FETCH;
        end
      endcase
      // Address follows the cycle about to begin
      unique case (next_state)
        ST_IO: next_addr = {9'h000, next_opa[PORT_W-1:0]};
        ST_TBL_XFER: next_addr = next_opa;
        ST_RESET: next_addr = address_out;
        default: next_addr = next_pc;
      endcase
    end
  end

  // Strobes are low in phases 1 to 3, at most one of them per cycle and none in reset
  always_comb
  begin
    strobe_on = (next_phase != PHASE_FIRST) && (next_state != ST_RESET) && pin_reset_n;
    next_fetch_n = 1'b1;
    next_read_n = 1'b1;
    next_write_n = 1'b1;
    if (strobe_on)
    begin
      unique case (next_state)
        ST_IO:
        begin
          next_read_n = (next_cur_op != OP_IN);
          next_write_n = (next_cur_op == OP_IN);
        end
        ST_TBL_XFER:
        begin
          next_write_n = (next_cur_op != OP_TABLE_WRITE_OP);
          next_fetch_n = (next_cur_op == OP_TABLE_WRITE_OP);
        end
        default: next_fetch_n = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      state <= ST_RESET;
      cur_op <= OP_NEXT;
      pc <= PC_RESET;
      address_out <= PC_RESET;
      opa <= '0;
      opd <= '0;
      rst_ends <= 2'h0;
      fetch_word_out <= '0;
      result_data_out <= '0;
      fetch_valid_out <= 1'b0;
      result_valid_out <= 1'b0;
      branch_taken_out <= 1'b0;
      irq_taken_out <= 1'b0;
      fetch_strobe_n_out <= 1'b1;
      input_read_strobe_n_out <= 1'b1;
      write_strobe_n_out <= 1'b1;
      data_bus_oe_n_out <= 1'b1;
      data_bus_out <= '0;
    end
    else
    begin
      state <= next_state;
      cur_op <= next_cur_op;
      pc <= next_pc;
      address_out <= next_addr;
      opa <= next_opa;
      opd <= next_opd;
      rst_ends <= next_rst_ends;
      fetch_word_out <= next_fetch_word;
      result_data_out <= next_result;
      fetch_valid_out <= next_fetch_valid;
      result_valid_out <= next_result_valid;
      branch_taken_out <= next_branch;
      irq_taken_out <= next_irq_taken;
      fetch_strobe_n_out <= next_fetch_n;
      input_read_strobe_n_out <= next_read_n;
      write_strobe_n_out <= next_write_n;
      data_bus_oe_n_out <= next_write_n;
      data_bus_out <= next_opd;
    end
  end

  // ****************************************
  // Register read port
  // ****************************************
  logic [DATA_W-1:0] next_rdata;
  logic [DATA_W-1:0] status_word;

  // Read data stand for one cycle only, zero otherwise
  always_comb
  begin
    status_word = '0;
    status_word[STAT_FLAG_BIT] = flag;
    status_word[STAT_MODE_BIT] = pin_mode;
    status_word[STAT_TEST_BIT] = !pin_test_n;
    status_word[STAT_RESET_BIT] = !pin_reset_n;
    status_word[STAT_IRQ_BIT] = irq_request;
    next_rdata = '0;
    if (reg_read_in)
    begin
      unique case (reg_addr_in)
        REG_CTRL: next_rdata = {14'h0000, ovm, int_en};
        REG_STATUS: next_rdata = status_word;
        REG_PC: next_rdata = {4'h0, pc};
        REG_MEM_ADDR: next_rdata = {5'h00, mem_ptr};
        default: next_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      reg_rdata_out <= '0;
    end
    else
    begin
      reg_rdata_out <= next_rdata;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking dbi_cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);

  clk_quarter_duty_a: assert property ($rose(cycle_clock_output_out) |-> ##1 cycle_clock_output_out
    ##1 !cycle_clock_output_out ##1 !cycle_clock_output_out ##1 cycle_clock_output_out)
    else $error("cycle clock not a quarter rate at half duty");
  write_excl_a: assert property (!write_strobe_n_out |-> fetch_strobe_n_out && input_read_strobe_n_out)
    else $error("strobe active beside write strobe");
  read_excl_a: assert property (!input_read_strobe_n_out |-> fetch_strobe_n_out && write_strobe_n_out)
    else $error("strobe active beside input strobe");
  write_source_a: assert property (!write_strobe_n_out |-> (state == ST_IO && cur_op == OP_OUT)
    || (state == ST_TBL_XFER && cur_op == OP_TABLE_WRITE_OP))
    else $error("write strobe outside output or table write");
  read_source_a: assert property (!input_read_strobe_n_out |-> state == ST_IO && cur_op == OP_IN)
    else $error("input strobe outside input cycle");
  fetch_cycle_a: assert property ((state == ST_FETCH && phase != PHASE_FIRST) |-> !fetch_strobe_n_out)
    else $error("fetch strobe missing in fetch cycle");
  reset_quiet_a: assert property (!pin_reset_n |=> fetch_strobe_n_out && input_read_strobe_n_out
    && write_strobe_n_out && data_bus_oe_n_out)
    else $error("bus not quiet in reset");
  reset_clear_a: assert property ($rose(rst_ends[1]) |-> pc == PC_RESET && address_out == PC_RESET)
    else $error("program counter not cleared in reset");
  reset_mask_a: assert property (!pin_reset_n |=> !int_en && !flag)
    else $error("interrupt state survives pin reset");
  flag_edge_a: assert property (($fell(pin_int_n) && pin_reset_n) |=> flag)
    else $error("interrupt edge not latched");
  bus_drive_a: assert property (!data_bus_oe_n_out |-> !write_strobe_n_out)
    else $error("data bus driven without write strobe");
  port_addr_a: assert property (state == ST_IO |-> address_out == {9'h000, opa[PORT_W-1:0]})
    else $error("port address wrong in port cycle");
  branch_take_a: assert property ((op_ready_out && op_valid_in && op_in == OP_BRANCH_TEST && !pin_test_n)
    |=> pc == $past(op_addr_in) && branch_taken_out)
    else $error("branch on low test input not taken");

endmodule

`default_nettype wire

// ==== tb/dbi_ext_mem.sv ====
// External program memory and port peripheral model
`default_nettype none
module dbi_ext_mem (
  input wire logic clk_in,
  input wire logic fetch_strobe_n_in,
  input wire logic input_read_strobe_n_in,
  input wire logic [11:0] address_in,
  output logic [15:0] data_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic sel;
  logic [15:0] last = 16'h5A5A;
  // Answers from strobe level alone, so clock skew never matters
  assign sel = !fetch_strobe_n_in || !input_read_strobe_n_in;
  // Released bus toggles each cycle so stale data never passes
  always_ff @(posedge clk_in)
  begin
    last <= sel ? {4'hA, address_in} : ~last;
  end
  assign data_out = sel ? {4'hA, address_in} : last;
endmodule
`default_nettype wire

// ==== tb/tb.sv ====
// Self-checking bench for the external bus interface block
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import dbi_pkg::*;
  logic clk_in = 1'h0, rst_in = 1'h1, rs_n = 1'h1, int_n = 1'h1, bio_n = 1'h1, mode = 1'h0;
  dbi_op_t op = OP_NEXT;
  logic op_v = 1'h0, wr = 1'h0, rd = 1'h0;
  logic [11:0] op_a = 12'h0, addr;
  logic [15:0] op_d = 16'h0, rw = 16'h0, ext_d, dout, res, rdat, fw;
  logic [2:0] ra = 3'h0;
  logic cko, fs_n, dn_n, we_n, oe_n, rdy, bt, rv, fv, it;
  int miscompares = 0, checked = 0, wl, dl, fl, bl, vl, vf;
  // ****************************************
  // Clock, design and far side
  // ****************************************
  initial
  begin
    forever #25 clk_in = ~clk_in;
  end
  dbi_bus_if dbi_bus_if_i (.clk_in(clk_in), .rst_in(rst_in), .reset_pin_n_in(rs_n),
    .interrupt_pin_n_in(int_n), .branch_test_input_n_in(bio_n), .memory_mode_select_in(mode),
    .cycle_clock_output_out(cko), .fetch_strobe_n_out(fs_n), .input_read_strobe_n_out(dn_n),
    .write_strobe_n_out(we_n), .address_out(addr), .data_bus_in(ext_d), .data_bus_out(dout),
    .data_bus_oe_n_out(oe_n), .op_in(op), .op_valid_in(op_v), .op_ready_out(rdy), .op_addr_in(op_a),
    .op_data_in(op_d), .fetch_word_out(fw), .fetch_valid_out(fv), .result_data_out(res),
    .result_valid_out(rv), .branch_taken_out(bt), .irq_taken_out(it), .reg_addr_in(ra),
    .reg_wdata_in(rw), .reg_write_in(wr), .reg_read_in(rd), .reg_rdata_out(rdat));
  dbi_ext_mem dbi_ext_mem_i (.clk_in(clk_in), .fetch_strobe_n_in(fs_n), .input_read_strobe_n_in(dn_n),
    .address_in(addr), .data_out(ext_d));
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e)
    begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wrap_up;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic reg_wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk_in);
    ra <= a;
    rw <= d;
    wr <= 1'h1;
    @(posedge clk_in);
    wr <= 1'h0;
  endtask
  task automatic reg_rd(input logic [2:0] a, input logic [15:0] e, input string nm);
    @(posedge clk_in);
    ra <= a;
    rd <= 1'h1;
    @(posedge clk_in);
    rd <= 1'h0;
    @(negedge clk_in);
    chk(nm, e, rdat);
  endtask
  // Offer one op, then watch the pins for three machine cycles
  task automatic run_op(input dbi_op_t o, input logic [11:0] a, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge clk_in);
    op <= o;
    op_a <= a;
    op_d <= d;
    op_v <= 1'h1;
    @(negedge clk_in);
    while (rdy !== 1'h1 && n < 40)
    begin
      @(negedge clk_in);
      n++;
    end
    @(posedge clk_in);
    op_v <= 1'h0;
    chk("op_taken", 16'h1, {15'h0, n < 40});
    wl = 0;
    dl = 0;
    fl = 0;
    bl = 0;
    vl = 0;
    vf = 0;
    repeat (12)
    begin
      @(negedge clk_in);
      fl += !fs_n;
      wl += !we_n;
      dl += !dn_n;
      bl += bt;
      vl += rv;
      vf += fv;
      if (!we_n) chk("wdata", d, dout);
      if (!we_n) chk("excl_we", 16'h3, {fs_n, dn_n});
      if (!dn_n) chk("excl_in", 16'h3, {fs_n, we_n});
      chk("oe_n", {15'h0, we_n}, {15'h0, oe_n});
      if (!we_n || !dn_n) chk("port_addr", a, addr);
    end
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic clk_test;
    int h, r;
    logic p;
    h = 0;
    r = 0;
    p = cko;
    repeat (40)
    begin
      @(negedge clk_in);
      h += cko;
      r += cko && !p;
      p = cko;
    end
    chk("clk_high", 16'h0014, h[15:0]);
    chk("clk_rises", 16'h000A, r[15:0]);
  endtask
  task automatic io_test;
    run_op(OP_OUT, 12'h005, 16'hC3A5);
    chk("out_we", 16'h3, wl[15:0]);
    chk("out_fetch_valid", 16'h2, vf[15:0]);
    chk("fetch_lows", 16'h1, {15'h0, fl > 3});
    run_op(OP_IN, 12'h006, 16'h0);
    chk("in_den", 16'h3, dl[15:0]);
    chk("in_valid", 16'h1, vl[15:0]);
    chk("in_data", 16'hA006, res);
    run_op(OP_TABLE_WRITE_OP, 12'h7F3, 16'h1234);
    chk("table_write_op_we", 16'h3, wl[15:0]);
    run_op(OP_TABLE_READ_OP, 12'h9AB, 16'h0);
    chk("table_read_op_data", 16'hA9AB, res);
    chk("table_read_op_strobes", 16'h0, wl[15:0] + dl[15:0]);
  endtask
  task automatic bio_test;
    @(posedge clk_in);
    bio_n <= 1'h0;
    // Let the pin synchroniser settle before the op is offered
    repeat (6) @(posedge clk_in);
    run_op(OP_BRANCH_TEST, 12'h040, 16'h0);
    chk("branch_low", 16'h1, bl[15:0]);
    @(posedge clk_in);
    bio_n <= 1'h1;
    repeat (6) @(posedge clk_in);
    run_op(OP_BRANCH_TEST, 12'h040, 16'h0);
    chk("branch_high", 16'h0, bl[15:0]);
  endtask
  task automatic mode_test;
    @(posedge clk_in);
    mode <= 1'h1;
    reg_wr(REG_MEM_ADDR, 16'h0010);
    reg_wr(REG_MEM_DATA, 16'hBEEF);
    reg_rd(REG_MEM_ADDR, 16'h0011, "mem_ptr");
    run_op(OP_JUMP, 12'h010, 16'h0);
    chk("onchip_word", 16'hBEEF, fw);
    run_op(OP_TABLE_READ_OP, 12'h010, 16'h0);
    chk("onchip_table_read_op", 16'hBEEF, res);
    run_op(OP_TABLE_READ_OP, 12'h5F5, 16'h0);
    chk("reserved", 16'h0, res);
    chk("onchip_fetch", 16'h1, {15'h0, fl > 3});
  endtask
  // Edge latched while disabled, then granted once enabled
  task automatic irq_test;
    int t;
    t = 0;
    @(posedge clk_in);
    int_n <= 1'h0;
    repeat (6) @(posedge clk_in);
    int_n <= 1'h1;
    repeat (6) @(posedge clk_in);
    reg_rd(REG_STATUS, 16'h0003, "flag_set");
    reg_wr(REG_CTRL, 16'h0001);
    while (it !== 1'h1 && t < 40)
    begin
      @(negedge clk_in);
      t++;
    end
    chk("irq_taken", 16'h1, {15'h0, t < 40});
    reg_rd(REG_PC, 16'h0002, "vector");
    reg_rd(REG_STATUS, 16'h0002, "flag_clear");
  endtask
  task automatic pin_reset_test;
    reg_wr(REG_CTRL, 16'h0003);
    @(posedge clk_in);
    rs_n <= 1'h0;
    repeat (24) @(negedge clk_in);
    chk("rst_strobes", 16'hF, {fs_n, dn_n, we_n, oe_n});
    chk("rst_addr", 16'h0, addr);
    reg_rd(REG_PC, 16'h0, "pc");
    reg_rd(REG_CTRL, 16'h0002, "ctrl");
    reg_rd(REG_STATUS, 16'h000A, "status");
    reg_rd(3'h7, 16'h0, "unmapped");
    @(posedge clk_in);
    rs_n <= 1'h1;
    run_op(OP_NEXT, 12'h000, 16'h0);
    reg_rd(REG_PC, 16'h0001, "pc_after_reset");
  endtask
  // Main sequence
  initial
  begin
    repeat (6) @(posedge clk_in);
    rst_in <= 1'h0;
    @(negedge clk_in);
    chk("init_strobes", 16'hF, {fs_n, dn_n, we_n, oe_n});
    chk("init_addr", 16'h0, addr);
    clk_test;
    io_test;
    bio_test;
    mode_test;
    irq_test;
    pin_reset_test;
    wrap_up;
  end
  // Watchdog
  initial
  begin
    repeat (3000) @(posedge clk_in);
    miscompares++;
    wrap_up;
  end
endmodule
`default_nettype wire
